// [strd_consts.svh]
// Constants for the SCSI transfer rate dividers: register offsets, field
// positions and reset values. Definitions only.
`ifndef STRD_CONSTS_SVH
`define STRD_CONSTS_SVH

// ==========================================================
// Register offsets
`define STRD_OFS_TRANSFER_TIMING 8'h05
`define STRD_OFS_BUS_LINE_CONTROL 8'h0B
`define STRD_OFS_SCRATCH_LOW 8'h10
`define STRD_OFS_TEST_NINE 8'h22
`define STRD_OFS_TEST_EIGHT 8'h23
`define STRD_OFS_DMA_CLOCK_CONTROL 8'h3B
`define STRD_OFS_SCRATCH_HIGH 8'h3C

// ==========================================================
// Field positions
`define STRD_SYNC_FACTOR_LO 0
`define STRD_SYNC_FACTOR_HI 1
`define STRD_CORE_FACTOR_LO 6
`define STRD_CORE_FACTOR_HI 7
`define STRD_PERIOD_LO 4
`define STRD_PERIOD_HI 6
`define STRD_T8_MASTER_FETCH 6
`define STRD_T8_SCLK_SEL 7
`define STRD_T8_ACTIVE_NEG 4

// ==========================================================
// Reset values
`define STRD_RST_BYTE 8'h00
`define STRD_RST_WORD 32'h0000_0000

`endif

// [strd_pkg.sv]
// Types shared by the SCSI transfer rate divider files.
// Assumes nothing of its surroundings.
package strd_pkg;
  // Register decode result
  typedef enum logic [2:0] {
    STRD_SEL_NONE,
    STRD_SEL_XFER,
    STRD_SEL_BUSLINE,
    STRD_SEL_SCRA,
    STRD_SEL_T9,
    STRD_SEL_T8,
    STRD_SEL_DMA,
    STRD_SEL_SCRB
  } strd_sel_type;
  // Divider phase
  typedef enum logic {
    STRD_DIV_IDLE,
    STRD_DIV_RUN
  } strd_div_state_type;
endpackage

// [strd_divider.sv]
// Programmable divider: emits a one-cycle enable every i_ratio source ticks.
// Assumes i_tick is a single-cycle enable on the same clock.
`timescale 1ns/10ps
module strd_divider #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Control
  input wire logic i_tick,
  input wire logic [WIDTH-1:0] i_ratio,
  // Output enable pulse
  output logic o_pulse
);
  import strd_pkg::*;
  logic [WIDTH-1:0] count_reg;
  strd_div_state_type state_reg;

  // ==========================================================
  // Counter; ratio 1 passes every tick straight through
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_reg <= '0;
      state_reg <= STRD_DIV_IDLE;
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= 1'b0;
      case (state_reg)
        STRD_DIV_IDLE: begin
          count_reg <= '0;
          state_reg <= STRD_DIV_RUN;
        end
        STRD_DIV_RUN: begin
          if (i_tick) begin
            if (count_reg + WIDTH'(1) >= i_ratio) begin
              count_reg <= '0;
              o_pulse <= 1'b1;
            end else begin
              count_reg <= count_reg + WIDTH'(1);
            end
          end
        end
        default: state_reg <= STRD_DIV_IDLE;
      endcase
    end
  end
endmodule // strd_divider

// [strd_rate_top.sv]
// SCSI transfer rate dividers with their control and test registers.
// Assumes a byte-wide register port on I_CLK and an external SCSI clock pin
// sampled as a level; dividers run on one-cycle enables derived from it.
`timescale 1ns/10ps
`include "strd_consts.svh"
module strd_rate_top (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // Register port
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  // Status inputs from the processor core
  input wire logic I_MASTER_ACTIVE,
  input wire logic I_OPCODE_FETCH,
  input wire logic I_SEND_SYNC,
  // SCSI clock pin
  input wire logic I_SCSI_CLK,
  // Pins and enables
  output logic O_MASTER_STATUS_B,
  output logic O_MASTER_STATUS_OE_B,
  output logic O_FETCH_B,
  output logic O_FETCH_OE_B,
  output logic O_ACTIVE_NEG_EN,
  output logic O_SYNC_LOGIC_EN,
  output logic O_CORE_LOGIC_EN,
  output logic O_XFER_STROBE,
  output strd_pkg::strd_sel_type O_LAST_SEL
);
  import strd_pkg::*;

  // ==========================================================
  // Reset release
  logic rst_meta_reg;
  logic rst_b_reg;
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_meta_reg <= 1'b0;
      rst_b_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_b_reg <= rst_meta_reg;
    end
  end

  // ==========================================================
  // Registers
  logic [7:0] transfer_timing_reg;
  logic [7:0] bus_line_control_reg;
  logic [7:0] test_control_nine_reg;
  logic [7:0] test_control_eight_reg;
  logic [7:0] dma_clock_control_reg;
  logic [31:0] scratch_low_word_reg;
  logic [31:0] scratch_high_word_reg;
  strd_sel_type sel;

  // Address decode; scratch words take four consecutive byte addresses
  always_comb begin
    sel = STRD_SEL_NONE;
    case (I_REG_ADDR)
      `STRD_OFS_TRANSFER_TIMING: sel = STRD_SEL_XFER;
      `STRD_OFS_BUS_LINE_CONTROL: sel = STRD_SEL_BUSLINE;
      `STRD_OFS_TEST_NINE: sel = STRD_SEL_T9;
      `STRD_OFS_TEST_EIGHT: sel = STRD_SEL_T8;
      `STRD_OFS_DMA_CLOCK_CONTROL: sel = STRD_SEL_DMA;
      default: begin
        if (I_REG_ADDR[7:2] == 6'(`STRD_OFS_SCRATCH_LOW >> 2)) begin
          sel = STRD_SEL_SCRA;
        end else if (I_REG_ADDR[7:2] == 6'(`STRD_OFS_SCRATCH_HIGH >> 2)) begin
          sel = STRD_SEL_SCRB;
        end
      end
    endcase
  end

  // Transfer timing; unmapped addresses decode to none and write nothing
  always_ff @(posedge I_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      transfer_timing_reg <= `STRD_RST_BYTE;
    end else if (I_REG_WR && sel == STRD_SEL_XFER) begin
      transfer_timing_reg <= I_REG_WDATA;
    end
  end

  // Bus line control; only the factor field reaches the logic
  always_ff @(posedge I_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      bus_line_control_reg <= `STRD_RST_BYTE;
    end else if (I_REG_WR && sel == STRD_SEL_BUSLINE) begin
      bus_line_control_reg <= I_REG_WDATA;
    end
  end

  // Test control nine; plain storage, no side effect
  always_ff @(posedge I_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      test_control_nine_reg <= `STRD_RST_BYTE;
    end else if (I_REG_WR && sel == STRD_SEL_T9) begin
      test_control_nine_reg <= I_REG_WDATA;
    end
  end

  // Test control eight; pin enables follow one cycle after the write
  always_ff @(posedge I_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      test_control_eight_reg <= `STRD_RST_BYTE;
    end else if (I_REG_WR && sel == STRD_SEL_T8) begin
      test_control_eight_reg <= I_REG_WDATA;
    end
  end

  // DMA clock control; a new core factor mid-run applies at once, a count
  // already at the new factor less one ends the period on the next tick
  always_ff @(posedge I_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      dma_clock_control_reg <= `STRD_RST_BYTE;
    end else if (I_REG_WR && sel == STRD_SEL_DMA) begin
      dma_clock_control_reg <= I_REG_WDATA;
    end
  end

  // Low scratch word; one byte lane per address
  always_ff @(posedge I_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      scratch_low_word_reg <= `STRD_RST_WORD;
    end else if (I_REG_WR && sel == STRD_SEL_SCRA) begin
      scratch_low_word_reg[I_REG_ADDR[1:0]*8 +: 8] <= I_REG_WDATA;
    end
  end

  // High scratch word; one byte lane per address
  always_ff @(posedge I_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      scratch_high_word_reg <= `STRD_RST_WORD;
    end else if (I_REG_WR && sel == STRD_SEL_SCRB) begin
      scratch_high_word_reg[I_REG_ADDR[1:0]*8 +: 8] <= I_REG_WDATA;
    end
  end

  // Decode of the last read address, kept for debug visibility
  always_ff @(posedge I_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      O_LAST_SEL <= STRD_SEL_NONE;
    end else if (I_REG_RD) begin
      O_LAST_SEL <= sel;
    end
  end

  // Read data; unmapped reads give zero, data holds until the next read
  always_ff @(posedge I_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      O_REG_RDATA <= 8'h00;
    end else if (I_REG_RD) begin
      case (sel)
        STRD_SEL_XFER: O_REG_RDATA <= transfer_timing_reg;
        STRD_SEL_BUSLINE: O_REG_RDATA <= bus_line_control_reg;
        STRD_SEL_T9: O_REG_RDATA <= test_control_nine_reg;
        STRD_SEL_T8: O_REG_RDATA <= test_control_eight_reg;
        STRD_SEL_DMA: O_REG_RDATA <= dma_clock_control_reg;
        STRD_SEL_SCRA: O_REG_RDATA <= scratch_low_word_reg[I_REG_ADDR[1:0]*8 +: 8];
        STRD_SEL_SCRB: O_REG_RDATA <= scratch_high_word_reg[I_REG_ADDR[1:0]*8 +: 8];
        default: O_REG_RDATA <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // SCSI clock source
  logic sclk_meta_reg;
  logic sclk_sync_reg;
  logic sclk_prev_reg;
  logic src_tick;
  always_ff @(posedge I_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_meta_reg <= I_SCSI_CLK;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_prev_reg <= sclk_sync_reg;
    end
  end
  // Pin edges only when selected, else the internal clock itself.
  // Pin rate is limited to half of I_CLK by the sampling.
  assign src_tick = test_control_eight_reg[`STRD_T8_SCLK_SEL] ?
                    (sclk_sync_reg & ~sclk_prev_reg) : 1'b1;

  // ==========================================================
  // Ratio decode; only the example codes are known, others are plain guesses
  function automatic logic [3:0] sync_ratio(input logic [1:0] code);
    case (code)
      2'h0: sync_ratio = 4'h2;
      2'h1: sync_ratio = 4'h1;
      2'h2: sync_ratio = 4'h2;
      default: sync_ratio = 4'h3;
    endcase
  endfunction

  function automatic logic [3:0] core_ratio(input logic [1:0] code);
    case (code)
      2'h0: core_ratio = 4'h2;
      2'h1: core_ratio = 4'h3;
      2'h2: core_ratio = 4'h1;
      default: core_ratio = 4'h4;
    endcase
  endfunction

  // Period codes 0..7 map to factors 4..11
  function automatic logic [3:0] period_ratio(input logic [2:0] code);
    period_ratio = {1'b0, code} + 4'h4;
  endfunction

  // ==========================================================
  // Divider chain; index 0 sync logic, 1 core logic, 2 transfer period
  logic [1:0] sync_code;
  logic [1:0] core_code;
  logic [2:0] period_code;
  logic [2:0] div_tick;
  logic [3:0] div_ratio [3];
  logic [2:0] div_pulse;
  logic sync_en;
  logic core_en;
  logic xfer_en;

  // Factor fields; a new code applies from the next source tick
  assign sync_code = bus_line_control_reg[`STRD_SYNC_FACTOR_HI:`STRD_SYNC_FACTOR_LO];
  assign core_code = dma_clock_control_reg[`STRD_CORE_FACTOR_HI:`STRD_CORE_FACTOR_LO];
  assign period_code = transfer_timing_reg[`STRD_PERIOD_HI:`STRD_PERIOD_LO];

  // Clock dividers share the source tick; period divider counts
  // sync enables only during a send, so an idle bus keeps its phase
  // where the last send stopped
  assign div_tick[0] = src_tick;
  assign div_tick[1] = src_tick;
  assign div_tick[2] = sync_en & I_SEND_SYNC;
  assign div_ratio[0] = sync_ratio(sync_code);
  assign div_ratio[1] = core_ratio(core_code);
  assign div_ratio[2] = period_ratio(period_code);
  assign sync_en = div_pulse[0];
  assign core_en = div_pulse[1];
  assign xfer_en = div_pulse[2];

  // One counter per rate
  for (genvar d = 0; d < 3; d++) begin : g_div
    strd_divider #(
      .WIDTH(4)
    ) u_div (
      .i_clk(I_CLK),
      .i_rst_b(rst_b_reg),
      .i_tick(div_tick[d]),
      .i_ratio(div_ratio[d]),
      .o_pulse(div_pulse[d])
    );
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge I_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      O_SYNC_LOGIC_EN <= 1'b0;
      O_CORE_LOGIC_EN <= 1'b0;
      O_XFER_STROBE <= 1'b0;
    end else begin
      O_SYNC_LOGIC_EN <= sync_en;
      O_CORE_LOGIC_EN <= core_en;
      O_XFER_STROBE <= xfer_en;
    end
  end

  // Master status pin; enable low while driving, released pin held high
  always_ff @(posedge I_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      O_MASTER_STATUS_B <= 1'b1;
      O_MASTER_STATUS_OE_B <= 1'b1;
    end else begin
      O_MASTER_STATUS_OE_B <= ~test_control_eight_reg[`STRD_T8_MASTER_FETCH];
      O_MASTER_STATUS_B <= ~(I_MASTER_ACTIVE &
                             test_control_eight_reg[`STRD_T8_MASTER_FETCH]);
    end
  end

  // Opcode fetch pin; one cycle behind the core's fetch level
  always_ff @(posedge I_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      O_FETCH_B <= 1'b1;
      O_FETCH_OE_B <= 1'b1;
    end else begin
      O_FETCH_OE_B <= ~test_control_eight_reg[`STRD_T8_MASTER_FETCH];
      O_FETCH_B <= ~(I_OPCODE_FETCH &
                     test_control_eight_reg[`STRD_T8_MASTER_FETCH]);
    end
  end

  // Active negation enable follows its bit
  always_ff @(posedge I_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      O_ACTIVE_NEG_EN <= 1'b0;
    end else begin
      O_ACTIVE_NEG_EN <= test_control_eight_reg[`STRD_T8_ACTIVE_NEG];
    end
  end
endmodule // strd_rate_top

// [strd_sclk_model.sv]
// Partner model: the SCSI clock pin that feeds the dividers.
// Assumes the bench raises i_run only while pin-sourced ticks are wanted.
`timescale 1ns/10ps
module strd_sclk_model (
  // Control
  input wire logic i_run,
  // Pin
  output logic o_sclk
);
  // ==========================================================
  // Clock source
  // Quarter rate, rests low between bursts so no stale edge leaks in;
  // the slow pin keeps every divided clock inside its limit
  initial begin
    o_sclk = 1'b0;
    forever begin
      #40;
      o_sclk = i_run ? ~o_sclk : 1'b0;
    end
  end
endmodule // strd_sclk_model

// [strd_rate_checker.sv]
// Concurrent checks on the rate divider top-level ports.
// Assumes it is bound to strd_rate_top; shadows written registers itself.
`timescale 1ns/10ps
module strd_rate_checker (
  // Clock, reset and register writes
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic [7:0] I_REG_WDATA,
  // Status inputs and outputs
  input wire logic I_OPCODE_FETCH,
  input wire logic I_SEND_SYNC,
  input wire logic I_SCSI_CLK,
  input wire logic O_MASTER_STATUS_OE_B,
  input wire logic O_FETCH_B,
  input wire logic O_FETCH_OE_B,
  input wire logic O_ACTIVE_NEG_EN,
  input wire logic O_SYNC_LOGIC_EN,
  input wire logic O_CORE_LOGIC_EN,
  input wire logic O_XFER_STROBE
);
  logic [7:0] t8;
  logic [1:0] bl, dm;
  logic [2:0] xp;
  logic [3:0] quiet, still, run;
  logic sclk_d;
  // ==========================================================
  // Shadows and settle counters; checks wait out config changes
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      {t8, bl, dm, xp} <= 15'h0000;
      {quiet, still, run, sclk_d} <= 13'h0000;
    end else begin
      if (I_REG_WR && I_REG_ADDR == 8'h23) t8 <= I_REG_WDATA;
      if (I_REG_WR && I_REG_ADDR == 8'h0B) bl <= I_REG_WDATA[1:0];
      if (I_REG_WR && I_REG_ADDR == 8'h3B) dm <= I_REG_WDATA[7:6];
      if (I_REG_WR && I_REG_ADDR == 8'h05) xp <= I_REG_WDATA[6:4];
      quiet <= I_REG_WR ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
      still <= (I_SCSI_CLK != sclk_d) ? 4'h0 : still + {3'h0, still != 4'hF};
      run <= !I_SEND_SYNC ? 4'h0 : run + {3'h0, run != 4'hF};
      sclk_d <= I_SCSI_CLK;
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_B);
  property p_neg; quiet > 3 |-> O_ACTIVE_NEG_EN == t8[4]; endproperty
  a_neg: assert property (p_neg) else $error("negation enable wrong");
  property p_rel; quiet > 3 && !t8[6] |-> O_MASTER_STATUS_OE_B && O_FETCH_OE_B; endproperty
  a_rel: assert property (p_rel) else $error("test pins driven");
  property p_fetch; quiet > 3 && t8[6] |-> !O_FETCH_OE_B && O_FETCH_B == !$past(I_OPCODE_FETCH);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch pin wrong");
  property p_sone; quiet > 12 && bl == 2'h1 && !t8[7] |-> O_SYNC_LOGIC_EN; endproperty
  a_sone: assert property (p_sone) else $error("sync ratio one");
  property p_ctwo; O_CORE_LOGIC_EN && quiet > 12 && dm == 2'h0 && !t8[7]
    |-> $past(O_CORE_LOGIC_EN, 2) && !$past(O_CORE_LOGIC_EN); endproperty
  a_ctwo: assert property (p_ctwo) else $error("core ratio two");
  property p_spul; O_SYNC_LOGIC_EN && quiet > 12 && bl != 2'h1 |-> !$past(O_SYNC_LOGIC_EN);
  endproperty
  a_spul: assert property (p_spul) else $error("sync pulse width");
  property p_xfer; O_XFER_STROBE && quiet > 12 && run > 12 && bl == 2'h1 && xp == 3'h0
    && !t8[7] |-> $past(O_XFER_STROBE, 4) && !$past(O_XFER_STROBE); endproperty
  a_xfer: assert property (p_xfer) else $error("period factor four");
  property p_pin; quiet > 12 && still > 10 && t8[7] |-> !O_SYNC_LOGIC_EN; endproperty
  a_pin: assert property (p_pin) else $error("pulse without pin edge");
endmodule // strd_rate_checker

// [testbench.sv]
// Self-checking bench: registers, divider ratios, pin source, test pins.
// Assumes design, checker and clock model files are compiled before it.
`timescale 1ns/10ps
module testbench;
  import strd_pkg::*;
  logic clk, rst_b, wr, rd, mst, fet, snd, run, sclk, pm, pf;
  logic [7:0] adr, wd, rdat;
  wire [2:0] pl;
  wire [4:0] pin;
  wire [2:0] ls;
  logic [7:0] mem[logic [7:0]];
  logic [7:0] regs[$] = '{8'h05, 8'h0B, 8'h10, 8'h13, 8'h22, 8'h23, 8'h3B, 8'h3C, 8'h3F};
  int sr[4] = '{2, 1, 2, 3};
  int cr[4] = '{2, 3, 1, 4};
  int errors, compares, n;
  // ==========================================================
  // Design and partner
  strd_rate_top strd_rate_top_inst (.I_CLK(clk), .I_RST_B(rst_b), .I_REG_ADDR(adr),
    .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wd), .O_REG_RDATA(rdat),
    .I_MASTER_ACTIVE(mst), .I_OPCODE_FETCH(fet), .I_SEND_SYNC(snd), .I_SCSI_CLK(sclk),
    .O_MASTER_STATUS_B(pin[3]), .O_MASTER_STATUS_OE_B(pin[2]), .O_FETCH_B(pin[1]),
    .O_FETCH_OE_B(pin[0]), .O_ACTIVE_NEG_EN(pin[4]), .O_SYNC_LOGIC_EN(pl[0]),
    .O_CORE_LOGIC_EN(pl[1]), .O_XFER_STROBE(pl[2]), .O_LAST_SEL(ls));
  strd_sclk_model strd_sclk_model_inst (.i_run(run), .o_sclk(sclk));
  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (e !== g) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chkn(input string s, input int e, input int g);
    compares++;
    if (e != g) begin
      errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", s, e, g);
    end
  endtask
  task automatic results;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Expected decode of a read address, from the register map
  function automatic logic [7:0] sel_of(input logic [7:0] a);
    strd_sel_type s;
    case (a) inside
      8'h05: s = STRD_SEL_XFER;
      8'h0B: s = STRD_SEL_BUSLINE;
      [8'h10:8'h13]: s = STRD_SEL_SCRA;
      8'h22: s = STRD_SEL_T9;
      8'h23: s = STRD_SEL_T8;
      8'h3B: s = STRD_SEL_DMA;
      [8'h3C:8'h3F]: s = STRD_SEL_SCRB;
      default: s = STRD_SEL_NONE;
    endcase
    return {5'h0, s};
  endfunction
  // Model keeps mapped bytes only; unmapped writes vanish
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a inside {regs}) mem[a] = d;
  endtask
  // Bus line register holds plain stored bits, yet only the factor field is compared
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", (mem.exists(a) ? mem[a] : 8'h00) & (a == 8'h0B ? 8'h03 : 8'hFF),
      rdat & (a == 8'h0B ? 8'h03 : 8'hFF));
    chk("last sel", sel_of(a), {5'h0, ls});
  endtask
  // Bounded wait for the next pulse; n ends as cycles waited
  task automatic wpl(input int s);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pl[s] !== 1'b1 && n < 200);
    if (n >= 200) begin
      errors++;
      results();
    end
  endtask
  task automatic gap(input int s, input int e);
    wpl(s);
    wpl(s);
    chkn("pulse gap", e, n);
  endtask
  task automatic none(input int s);
    repeat (10) @(negedge clk);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      n += int'(pl[s] !== 1'b0);
    end
    chkn("idle pulses", 0, n);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {rst_b, wr, rd, mst, fet, snd, run} = 7'h00;
    {adr, wd} = 16'h0000;
    errors = 0;
    compares = 0;
    n = $urandom(32'h3CCF);
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (regs[i]) rreg(regs[i]);
    foreach (regs[i]) wreg(regs[i], 8'($urandom));
    wreg(8'h40, 8'hA5);
    foreach (regs[i]) rreg(regs[i]);
    rreg(8'h40);
    wreg(8'h23, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wreg(8'h0B, 8'(c));
      wreg(8'h3B, 8'(c << 6));
      repeat (16) @(posedge clk);
      gap(0, sr[c]);
      gap(1, cr[c]);
    end
    wreg(8'h0B, 8'h01);
    snd <= 1'b1;
    for (int p = 0; p < 8; p++) begin
      wreg(8'h05, 8'(p << 4) | (8'($urandom) & 8'h8F));
      repeat (16) @(posedge clk);
      gap(2, p + 4);
    end
    wreg(8'h0B, 8'h03);
    repeat (16) @(posedge clk);
    gap(2, 33);
    @(posedge clk) snd <= 1'b0;
    none(2);
    wreg(8'h0B, 8'h01);
    wreg(8'h3B, 8'h00);
    wreg(8'h23, 8'h80);
    run <= 1'b1;
    repeat (16) @(posedge clk);
    gap(0, 4);
    gap(1, 8);
    @(posedge clk) run <= 1'b0;
    none(0);
    wreg(8'h23, 8'h50);
    repeat (4) @(posedge clk);
    repeat (24) begin
      @(posedge clk);
      pm = mst;
      pf = fet;
      mst <= 1'($urandom);
      fet <= 1'($urandom);
      @(negedge clk);
      chk("pins", {3'h0, 1'b1, ~pm, 1'b0, ~pf, 1'b0}, {3'h0, pin});
    end
    wreg(8'h23, 8'h00);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("pins", 8'h0F, {3'h0, pin});
    results();
  end
endmodule // testbench
bind strd_rate_top strd_rate_checker strd_rate_checker_inst (.*);
